// *** palette_regs.svh ***
`ifndef PALETTE_REGS_SVH
`define PALETTE_REGS_SVH
// Direct register offsets on the host port
`define PAL_WRITE_POINTER_OFS 2'h0
`define PAL_COLOR_DATA_OFS    2'h1
`define PAL_READ_MASK_OFS     2'h2
`define PAL_READ_POINTER_OFS  2'h3
// Miscellaneous-control field positions
`define PAL_WIDTH_PIN_OVERRIDE_BIT 2
`define PAL_WIDTH_SOFT_SELECT_BIT  3
// Reset values
`define PAL_POINTER_RESET   8'h00
`define PAL_READ_MASK_RESET 8'hFF
// Host access completes within this many clocks
`define PAL_ACCESS_CYCLES 1
`endif

// *** palette_pkg.sv ***
package palette_pkg;
  typedef enum logic [1:0] {
    PHASE_RED,
    PHASE_GREEN,
    PHASE_BLUE
  } color_phase_type;
  typedef logic [7:0]  byte_type;
  typedef logic [23:0] color_type;
endpackage

// *** palette_ram.sv ***
`timescale 1ns/1ps
module palette_ram (
  input  wire logic         clock,
  input  wire logic         host_we,
  input  wire logic [7:0]   host_addr,
  input  wire logic [23:0]  host_wdata,
  output logic      [23:0]  host_rdata,
  input  wire logic [7:0]   pix_addr,
  output logic      [23:0]  pix_rdata
);
  // Two independent ports: host traffic never stalls pixel lookups
  logic [23:0] mem [0:255];

  always_ff @(posedge clock) begin
    if (host_we) begin
      mem[host_addr] <= host_wdata;
    end
    host_rdata <= mem[host_addr];
    pix_rdata  <= mem[pix_addr];
  end
endmodule

// *** color_palette_ram_access.sv ***
`timescale 1ns/1ps
`include "palette_regs.svh"
// Summary of operation
// - One 8-bit location pointer auto-advances after each completed color triple.
// - Pointer wraps from the last location back to zero.
// - Each host access completes within one clock cycle.
// - Each location stores 24 bits: red, green, blue bytes.
// - Six-bit mode stores full bytes but reads back top two bits as zero.
// - Six-bit mode shifts low six bits up, zero-filling two LSBs, toward DAC.
// - Test capture data taken after the output multiplexer.
// - After blue write, entry commits and pointer advances.
// - Host loads read pointer at 3; three data reads return red, green, blue.
// - After blue read, pointer advances to next location.
// - Table is dual ported; pixel lookups continue during host reads.
// - Width pin selects mode unless override bit set; then soft bit selects.
// - Pixel address ANDed bitwise with read mask before lookup.
module color_palette_ram_access
  import palette_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire logic [1:0]           host_addr,
  input  wire logic                 host_wr,
  input  wire logic                 host_rd,
  input  wire palette_pkg::byte_type host_wdata,
  output palette_pkg::byte_type     host_rdata,
  input  wire logic                 width_pin,
  input  wire palette_pkg::byte_type misc_control,
  input  wire palette_pkg::byte_type pixel_addr,
  output palette_pkg::byte_type     dac_red,
  output palette_pkg::byte_type     dac_green,
  output palette_pkg::byte_type     dac_blue,
  output palette_pkg::color_type    test_data
);
  import palette_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  color_phase_type phase_r, phase_nxt;
  byte_type        pointer_r, pointer_nxt;
  byte_type        mask_r, mask_nxt;
  byte_type        red_r, red_nxt;
  byte_type        green_r, green_nxt;
  byte_type        ram_addr;
  byte_type        host_rdata_r, host_rdata_nxt;
  logic            ram_we;
  color_type       ram_wdata;
  color_type       ram_rdata;
  color_type       pix_rdata;
  byte_type        pix_masked;
  logic            eight_bit;
  byte_type        rd_byte;
  logic            data_wr;
  logic            data_rd;

  assign data_wr   = host_wr && (host_addr == `PAL_COLOR_DATA_OFS);
  assign data_rd   = host_rd && (host_addr == `PAL_COLOR_DATA_OFS);
  // Override bit hands the width choice to software
  assign eight_bit = misc_control[`PAL_WIDTH_PIN_OVERRIDE_BIT] ?
                     misc_control[`PAL_WIDTH_SOFT_SELECT_BIT] : width_pin;
  assign pix_masked = pixel_addr & mask_r;
  assign ram_we    = data_wr && (phase_r == PHASE_BLUE);
  assign ram_wdata = {red_r, green_r, host_wdata};
  // Fetch ahead at the next pointer so a read just after a pointer load or a blue
  // read sees its entry; a blue write holds the port, so a data read in the very
  // next cycle still sees the previous fetch
  assign ram_addr  = ram_we ? pointer_r : pointer_nxt;

  ////////////////////////////////////////////////////////////////////////////
  palette_ram u_ram (
    .clock      (clock),
    .host_we    (ram_we),
    .host_addr  (ram_addr),
    .host_wdata (ram_wdata),
    .host_rdata (ram_rdata),
    .pix_addr   (pix_masked),
    .pix_rdata  (pix_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (phase_r)
      PHASE_RED:   rd_byte = ram_rdata[23:16];
      PHASE_GREEN: rd_byte = ram_rdata[15:8];
      PHASE_BLUE:  rd_byte = ram_rdata[7:0];
      default:     rd_byte = 8'h00;
    endcase
    if (!eight_bit) begin
      rd_byte[7:6] = 2'b00;
    end
  end

  always_comb begin
    phase_nxt      = phase_r;
    pointer_nxt    = pointer_r;
    mask_nxt       = mask_r;
    red_nxt        = red_r;
    green_nxt      = green_r;
    host_rdata_nxt = host_rdata_r;
    if (host_wr) begin
      case (host_addr)
        `PAL_WRITE_POINTER_OFS: begin
          pointer_nxt = host_wdata;
          phase_nxt   = PHASE_RED;
        end
        `PAL_READ_POINTER_OFS: begin
          pointer_nxt = host_wdata;
          phase_nxt   = PHASE_RED;
        end
        `PAL_READ_MASK_OFS: begin
          mask_nxt = host_wdata;
        end
        default: begin
          case (phase_r)
            PHASE_RED: begin
              red_nxt   = host_wdata;
              phase_nxt = PHASE_GREEN;
            end
            PHASE_GREEN: begin
              green_nxt = host_wdata;
              phase_nxt = PHASE_BLUE;
            end
            default: begin
              phase_nxt   = PHASE_RED;
              pointer_nxt = pointer_r + 8'h01;
            end
          endcase
        end
      endcase
    end else if (host_rd) begin
      case (host_addr)
        `PAL_WRITE_POINTER_OFS, `PAL_READ_POINTER_OFS: begin
          host_rdata_nxt = pointer_r;
        end
        `PAL_READ_MASK_OFS: begin
          host_rdata_nxt = mask_r;
        end
        default: begin
          host_rdata_nxt = rd_byte;
          case (phase_r)
            PHASE_RED:   phase_nxt = PHASE_GREEN;
            PHASE_GREEN: phase_nxt = PHASE_BLUE;
            default: begin
              phase_nxt   = PHASE_RED;
              pointer_nxt = pointer_r + 8'h01;
            end
          endcase
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phase_r      <= PHASE_RED;
      pointer_r    <= `PAL_POINTER_RESET;
      mask_r       <= `PAL_READ_MASK_RESET;
      red_r        <= 8'h00;
      green_r      <= 8'h00;
      host_rdata_r <= 8'h00;
    end else begin
      phase_r      <= phase_nxt;
      pointer_r    <= pointer_nxt;
      mask_r       <= mask_nxt;
      red_r        <= red_nxt;
      green_r      <= green_nxt;
      host_rdata_r <= host_rdata_nxt;
    end
  end

  assign host_rdata = host_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Output multiplexer; test capture taps here so the whole path is covered
  color_type out_nxt, out_r;

  always_comb begin
    if (eight_bit) begin
      out_nxt = pix_rdata;
    end else begin
      out_nxt = {pix_rdata[21:16], 2'b00, pix_rdata[13:8], 2'b00,
                 pix_rdata[5:0], 2'b00};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      out_r <= 24'h00_0000;
    end else begin
      out_r <= out_nxt;
    end
  end

  assign dac_red   = out_r[23:16];
  assign dac_green = out_r[15:8];
  assign dac_blue  = out_r[7:0];
  assign test_data = out_r;

  ////////////////////////////////////////////////////////////////////////////
  ptr_wrap_a: assert property (@(posedge clock) disable iff (rst)
    (data_wr && phase_r == PHASE_BLUE && pointer_r == 8'hFF) |=> pointer_r == 8'h00)
    else $error("pointer did not wrap");
  wr_advance_a: assert property (@(posedge clock) disable iff (rst)
    (host_wr && host_addr == `PAL_WRITE_POINTER_OFS) ##1 (data_wr && !host_rd)[*3]
    |=> pointer_r == $past(pointer_r, 3) + 8'h01)
    else $error("pointer not advanced after blue write");
  rd_advance_a: assert property (@(posedge clock) disable iff (rst)
    (data_rd && !host_wr && phase_r == PHASE_BLUE) |=> pointer_r == $past(pointer_r) + 8'h01)
    else $error("pointer not advanced after blue read");
  phase_restart_a: assert property (@(posedge clock) disable iff (rst)
    (host_wr && (host_addr == `PAL_WRITE_POINTER_OFS || host_addr == `PAL_READ_POINTER_OFS))
    |=> phase_r == PHASE_RED)
    else $error("phase not restarted");
  six_bit_read_a: assert property (@(posedge clock) disable iff (rst)
    (data_rd && !host_wr && !eight_bit) |=> host_rdata[7:6] == 2'b00)
    else $error("six-bit readback not masked");
  six_bit_dac_a: assert property (@(posedge clock) disable iff (rst)
    !eight_bit |=> out_r[1:0] == 2'b00 && out_r[9:8] == 2'b00 && out_r[17:16] == 2'b00)
    else $error("six-bit dac data not realigned");
  green_latch_a: assert property (@(posedge clock) disable iff (rst)
    (data_wr && phase_r == PHASE_GREEN) |=> green_r == $past(host_wdata) && phase_r == PHASE_BLUE)
    else $error("green byte not latched");
  mask_load_a: assert property (@(posedge clock) disable iff (rst)
    (host_wr && host_addr == `PAL_READ_MASK_OFS) |=> mask_r == $past(host_wdata))
    else $error("read mask not loaded");
  width_select_a: assert property (@(posedge clock) disable iff (rst)
    misc_control[`PAL_WIDTH_PIN_OVERRIDE_BIT] |-> eight_bit == misc_control[`PAL_WIDTH_SOFT_SELECT_BIT])
    else $error("override ignored");

  triple_write_c: cover property (@(posedge clock) disable iff (rst) ram_we);
  triple_read_c: cover property (@(posedge clock) disable iff (rst)
    data_rd && phase_r == PHASE_BLUE);
  wrap_c: cover property (@(posedge clock) disable iff (rst)
    ram_we && pointer_r == 8'hFF);
  six_bit_c: cover property (@(posedge clock) disable iff (rst) data_rd && !eight_bit);
endmodule

// *** host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic                   clock,
  output logic                  [1:0] host_addr,
  output logic                        host_wr,
  output logic                        host_rd,
  output palette_pkg::byte_type       host_wdata,
  input  wire palette_pkg::byte_type  host_rdata
);
  import palette_pkg::*;
  initial begin
    host_addr  = 2'h0;
    host_wr    = 1'b0;
    host_rd    = 1'b0;
    host_wdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One transfer per cycle; a burst ends with an idle call, so strobes never linger
  task automatic op(input logic wr, input logic rd, input logic [1:0] a,
                    input byte_type d, output byte_type q);
    host_wr    = wr;
    host_rd    = rd;
    host_addr  = a;
    // Undriven data lines must not look like the last byte
    host_wdata = wr ? d : ~host_wdata;
    @(posedge clock);
    #1;
    q = host_rdata;
  endtask
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
`include "palette_regs.svh"
module testbench;
  import palette_pkg::*;
  logic       clock, rst, host_wr, host_rd, width_pin;
  logic [1:0] host_addr;
  byte_type   host_wdata, host_rdata, misc_control, pixel_addr, dac_red, dac_green, dac_blue;
  byte_type   q, mask;
  color_type  test_data, c;
  color_type  mem [256];
  int         n_fail, compares, seed, i;
  color_palette_ram_access dut (.clock(clock), .rst(rst), .host_addr(host_addr),
    .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
    .width_pin(width_pin), .misc_control(misc_control), .pixel_addr(pixel_addr),
    .dac_red(dac_red), .dac_green(dac_green), .dac_blue(dac_blue), .test_data(test_data));
  host_model host (.clock(clock), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic results();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input byte_type d);
    host.op(1'b1, 1'b0, a, d, q);
  endtask
  task automatic rd(input logic [1:0] a);
    host.op(1'b0, 1'b1, a, 8'h00, q);
  endtask
  function automatic logic six_mode();
    if (misc_control[`PAL_WIDTH_PIN_OVERRIDE_BIT]) return !misc_control[`PAL_WIDTH_SOFT_SELECT_BIT];
    return !width_pin;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic load(input byte_type p, input int n);
    wr(`PAL_WRITE_POINTER_OFS, p);
    for (int j = 0; j < n; j++) begin
      c = 24'($random(seed));
      mem[byte_type'(p + j)] = c;
      wr(`PAL_COLOR_DATA_OFS, c[23:16]);
      wr(`PAL_COLOR_DATA_OFS, c[15:8]);
      wr(`PAL_COLOR_DATA_OFS, c[7:0]);
    end
  endtask
  task automatic verify(input byte_type p, input int n);
    byte_type m;
    wr(`PAL_READ_POINTER_OFS, p);
    for (int j = 0; j < n; j++) begin
      m = six_mode() ? 8'h3F : 8'hFF;
      c = mem[byte_type'(p + j)];
      rd(`PAL_COLOR_DATA_OFS);
      check("red", c[23:16] & m, q);
      rd(`PAL_COLOR_DATA_OFS);
      check("green", c[15:8] & m, q);
      rd(`PAL_COLOR_DATA_OFS);
      check("blue", c[7:0] & m, q);
    end
    rd(`PAL_WRITE_POINTER_OFS);
    check("pointer", byte_type'(p + n), q);
  endtask
  // Host reads of the mask run while the pixel lookup is in flight
  task automatic pixel(input byte_type a);
    color_type e;
    pixel_addr = a;
    rd(`PAL_READ_MASK_OFS);
    rd(`PAL_READ_MASK_OFS);
    check("mask", mask, q);
    e = mem[a & mask];
    if (six_mode()) e = {e[21:16], 2'b00, e[13:8], 2'b00, e[5:0], 2'b00};
    check("dac", e, {dac_red, dac_green, dac_blue});
    check("test data", e, test_data);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
  initial begin
    seed = 32'h2466_5156;
    n_fail = 0;
    compares = 0;
    rst = 1'b1;
    width_pin = 1'b1;
    misc_control = 8'h00;
    pixel_addr = 8'h00;
    mask = `PAL_READ_MASK_RESET;
    repeat (6) @(posedge clock);
    #1;
    rst = 1'b0;
    rd(`PAL_WRITE_POINTER_OFS);
    check("pointer reset", `PAL_POINTER_RESET, q);
    rd(`PAL_READ_MASK_OFS);
    check("mask reset", `PAL_READ_MASK_RESET, q);
    load(8'hFE, 256);
    // A dropped partial triple must not shift the next one
    wr(`PAL_WRITE_POINTER_OFS, 8'h10);
    wr(`PAL_COLOR_DATA_OFS, 8'hA5);
    wr(`PAL_COLOR_DATA_OFS, 8'h5A);
    load(8'h10, 1);
    for (i = 0; i < 4; i++) begin
      width_pin = i[0];
      misc_control = {4'($random(seed)), ~i[0], i[1], 2'($random(seed))};
      verify(8'hFE, 4);
      verify(8'h10, 1);
      mask = (i == 0) ? 8'h10 : 8'($random(seed));
      wr(`PAL_READ_MASK_OFS, mask);
      pixel(8'hFF);
      repeat (4) pixel(8'($random(seed)));
    end
    host.op(1'b0, 1'b0, 2'h0, 8'h00, q);
    results();
  end
endmodule
